// ==== design/sbsf_pkg.sv ====
// Constants, register map and carrier types of the serial buffer flag block.
`default_nettype none
package sbsf_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_HALF_NS   = 64;
  localparam int SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = $clog2(SCK_HALF_CYC + 1);

  localparam logic [4:0] ADR_STAT = 5'h00;
  localparam logic [4:0] ADR_CTRL = 5'h04;
  localparam logic [4:0] ADR_BUF  = 5'h08;
  localparam logic [4:0] ADR_ISTA = 5'h0C;
  localparam logic [4:0] ADR_IEN  = 5'h10;
  localparam logic [4:0] ADR_ICLR = 5'h14;

  localparam int STAT_EN   = 15;
  localparam int STAT_SIDL = 13;
  localparam int STAT_ROV  = 6;
  localparam int STAT_TBF  = 1;
  localparam int STAT_RBF  = 0;

  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OV = 2;
  localparam int IRQ_W  = 3;

  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       dis_sck;
    logic       dis_sdo;
    logic       mode16;
    logic       smp;
    logic       cke;
    logic       ssen;
    logic       ckp;
    logic       msten;
    logic [2:0] spre;
    logic [1:0] ppre;
  } sbsf_ctrl_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] dat;
  } sbsf_wb_req_t;

  typedef enum {M_IDLE, M_RUN} sbsf_mstate_t;
endpackage
`default_nettype wire

// ==== design/sbsf_core.sv ====
// Wishbone slave, shift engine and status flags of the serial port.
//
// The implementer's own choices: register access over Wishbone and the address map.
`default_nettype none
module sbsf_core (
  input  wire logic        clk_i,    // 125 MHz clock
  input  wire logic        rst_i,    // Synchronous reset, high
  input  wire logic        wb_cyc_i, // Bus cycle
  input  wire logic        wb_stb_i, // Bus strobe
  input  wire logic        wb_we_i,  // Write enable
  input  wire logic [3:0]  wb_sel_i, // Byte lanes
  input  wire logic [4:0]  wb_adr_i, // Byte address
  input  wire logic [31:0] wb_dat_i, // Write data
  output logic      [31:0] wb_dat_o, // Read data
  output logic             wb_ack_o, // Acknowledge
  output logic             irq_o,    // Interrupt level
  input  wire logic        sck_i,    // Shift clock pin in
  output logic             sck_o,    // Shift clock pin out
  output logic             sck_oe_o, // Shift clock drive enable
  input  wire logic        sdi_i,    // Serial data in
  output logic             sdo_o,    // Serial data out
  output logic             sdo_oe_o, // Serial data drive enable
  input  wire logic        ss_n_i    // Slave select, low
);
  localparam int DIV_W = sbsf_pkg::DIV_W;
  localparam logic [DIV_W-1:0] HALF_LAST =
    DIV_W'(sbsf_pkg::SCK_HALF_CYC - 1);

  logic sck_m, sck_s, sck_d, sdi_m, sdi_s, ssn_m, ssn_s;
  always_ff @(posedge clk_i) begin
    sck_m <= sck_i;
    sck_s <= sck_m;
    sck_d <= sck_s;
    sdi_m <= sdi_i;
    sdi_s <= sdi_m;
    ssn_m <= ss_n_i;
    ssn_s <= ssn_m;
  end

  sbsf_pkg::sbsf_wb_req_t req;
  assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};

  sbsf_pkg::sbsf_ctrl_t  ctrl, next_ctrl;
  sbsf_pkg::sbsf_mstate_t mst, next_mst;
  logic                   en, next_en, sidl, next_sidl;
  logic [15:0]            txb, next_txb, sr, next_sr;
  logic [15:0]            rx_sh, next_rx_sh, rxb, next_rxb;
  logic                   tbf, next_tbf, rbf, next_rbf, rov, next_rov;
  logic                   busy, next_busy, phase, next_phase;
  logic [DIV_W-1:0]       div, next_div;
  logic [5:0]             edges, next_edges;
  logic [4:0]             samples, next_samples;
  logic [sbsf_pkg::IRQ_W-1:0] istat, next_istat, ien, next_ien;
  logic                   next_ack, next_irq;
  logic [31:0]            next_dat;
  logic                   next_sck, next_sck_oe, next_sdo, next_sdo_oe;
  logic                   hit, wr, rd_buf, wr_buf, rov_clr;
  logic                   tick, lead, trail, sample, shift, load, done;
  logic [4:0]             nbits;
  logic [15:0]            word;
  logic [sbsf_pkg::IRQ_W-1:0] ev, clr;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8],
               sel[0] ? dat[7:0]  : old[7:0]};
  endfunction

  always_comb begin
    next_ctrl    = ctrl;
    next_mst     = mst;
    next_en      = en;
    next_sidl    = sidl;
    next_txb     = txb;
    next_sr      = sr;
    next_rx_sh   = rx_sh;
    next_rxb     = rxb;
    next_tbf     = tbf;
    next_rbf     = rbf;
    next_rov     = rov;
    next_busy    = busy;
    next_phase   = phase;
    next_div     = div;
    next_edges   = edges;
    next_samples = samples;
    next_ien     = ien;
    ev           = '0;
    clr          = '0;
    load         = 1'b0;
    done         = 1'b0;
    word         = '0;
    tick         = 1'b0;
    lead         = 1'b0;
    trail        = 1'b0;
    nbits = ctrl.mode16 ? sbsf_pkg::WORD_BITS : sbsf_pkg::BYTE_BITS;

    // Writes and read side effects land on the edge that carries ack.
    hit     = req.cyc & req.stb;
    wr      = hit & req.we & wb_ack_o;
    rd_buf  = hit & ~req.we & wb_ack_o & (req.adr == sbsf_pkg::ADR_BUF);
    wr_buf  = wr & (req.adr == sbsf_pkg::ADR_BUF) & (|req.sel[1:0]);
    rov_clr = wr & (req.adr == sbsf_pkg::ADR_STAT) & req.sel[0] &
              ~req.dat[sbsf_pkg::STAT_ROV];
    next_ack = hit & ~wb_ack_o;

    if (wr && req.adr == sbsf_pkg::ADR_STAT && req.sel[1]) begin
      next_en   = req.dat[sbsf_pkg::STAT_EN];
      next_sidl = req.dat[sbsf_pkg::STAT_SIDL];
    end
    if (wr && req.adr == sbsf_pkg::ADR_CTRL) begin
      next_ctrl      = merge16(ctrl, req.dat[15:0], req.sel[1:0]);
      next_ctrl.rsvd = '0;
    end
    if (wr && req.adr == sbsf_pkg::ADR_IEN && req.sel[0])
      next_ien = req.dat[sbsf_pkg::IRQ_W-1:0];
    if (wr && req.adr == sbsf_pkg::ADR_ICLR && req.sel[0])
      clr = req.dat[sbsf_pkg::IRQ_W-1:0];
    if (wr_buf)
      next_txb = merge16(txb, req.dat[15:0], req.sel[1:0]);

    // Edge finding: the divider in master mode, the pin in slave mode.
    if (ctrl.msten) begin
      tick  = (mst == sbsf_pkg::M_RUN) && (div == HALF_LAST);
      lead  = tick & ~phase;
      trail = tick & phase;
    end else if (en && !(ctrl.ssen && ssn_s)) begin
      lead  = (sck_s ^ ctrl.ckp) & ~(sck_d ^ ctrl.ckp);
      trail = ~(sck_s ^ ctrl.ckp) & (sck_d ^ ctrl.ckp);
    end
    sample = ctrl.cke ? lead : trail;
    shift  = (ctrl.cke ? trail : lead) && (samples != '0);

    if (mst == sbsf_pkg::M_RUN) begin
      next_div = tick ? '0 : DIV_W'(div + 1'b1);
      if (tick) begin
        next_phase = ~phase;
        next_edges = edges + 6'h01;
        if (edges + 6'h01 == {nbits, 1'b0})
          next_mst = sbsf_pkg::M_IDLE;
      end
    end

    if (shift)
      next_sr = {sr[14:0], 1'b0};
    if (sample) begin
      next_rx_sh   = {rx_sh[14:0], sdi_s};
      next_samples = samples + 5'h01;
      if (samples + 5'h01 == nbits) begin
        done         = 1'b1;
        next_samples = '0;
        next_busy    = 1'b0;
        word = ctrl.mode16 ? next_rx_sh : {8'h00, next_rx_sh[7:0]};
      end
    end
    // A frame cut by deselect ends here so the next word can still load.
    if (!ctrl.msten && ctrl.ssen && ssn_s) begin
      next_samples = '0;
      if (samples != '0)
        next_busy = 1'b0;
    end

    // Hand the waiting word to the shift register.
    if (en && tbf && ctrl.msten && mst == sbsf_pkg::M_IDLE) begin
      load       = 1'b1;
      next_mst   = sbsf_pkg::M_RUN;
      next_div   = '0;
      next_edges = '0;
      next_phase = 1'b0;
    end else if (en && tbf && !ctrl.msten && !busy && samples == '0) begin
      load      = 1'b1;
      next_busy = 1'b1;
    end
    if (load) begin
      next_sr  = txb;
      next_tbf = 1'b0;
      ev[sbsf_pkg::IRQ_TX] = 1'b1;
    end
    if (wr_buf)
      next_tbf = 1'b1;

    if (rd_buf)
      next_rbf = 1'b0;
    if (rov_clr)
      next_rov = 1'b0;
    if (done) begin
      if (rbf && !rd_buf) begin
        next_rov = 1'b1;
        ev[sbsf_pkg::IRQ_OV] = 1'b1;
      end else begin
        next_rxb = word;
        next_rbf = 1'b1;
        ev[sbsf_pkg::IRQ_RX] = 1'b1;
      end
    end

    if (!en) begin
      next_mst     = sbsf_pkg::M_IDLE;
      next_samples = '0;
      next_busy    = 1'b0;
      next_phase   = 1'b0;
    end

    next_istat = (istat & ~clr) | ev;
    next_irq   = |(next_istat & next_ien);

    next_dat = '0;
    if (hit && !wb_ack_o) begin
      case (req.adr)
        sbsf_pkg::ADR_STAT: begin
          next_dat[sbsf_pkg::STAT_EN]   = en;
          next_dat[sbsf_pkg::STAT_SIDL] = sidl;
          next_dat[sbsf_pkg::STAT_ROV]  = rov;
          next_dat[sbsf_pkg::STAT_TBF]  = tbf;
          next_dat[sbsf_pkg::STAT_RBF]  = rbf;
        end
        sbsf_pkg::ADR_CTRL: next_dat[15:0] = ctrl;
        sbsf_pkg::ADR_BUF:  next_dat[15:0] = rxb;
        sbsf_pkg::ADR_ISTA: next_dat[sbsf_pkg::IRQ_W-1:0] = istat;
        sbsf_pkg::ADR_IEN:  next_dat[sbsf_pkg::IRQ_W-1:0] = ien;
        default:            next_dat = '0;
      endcase
    end

    next_sck_oe = en & ctrl.msten & ~ctrl.dis_sck;
    next_sck    = ctrl.ckp ^ next_phase;
    next_sdo    = ctrl.mode16 ? next_sr[15] : next_sr[7];
    next_sdo_oe = en & ~ctrl.dis_sdo &
                  (ctrl.msten | ~ctrl.ssen | ~ssn_s);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= '0;
      mst      <= sbsf_pkg::M_IDLE;
      en       <= 1'b0;
      sidl     <= 1'b0;
      txb      <= '0;
      sr       <= '0;
      rx_sh    <= '0;
      rxb      <= '0;
      tbf      <= 1'b0;
      rbf      <= 1'b0;
      rov      <= 1'b0;
      busy     <= 1'b0;
      phase    <= 1'b0;
      div      <= '0;
      edges    <= '0;
      samples  <= '0;
      istat    <= '0;
      ien      <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      irq_o    <= 1'b0;
      sck_o    <= 1'b0;
      sck_oe_o <= 1'b0;
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      mst      <= next_mst;
      en       <= next_en;
      sidl     <= next_sidl;
      txb      <= next_txb;
      sr       <= next_sr;
      rx_sh    <= next_rx_sh;
      rxb      <= next_rxb;
      tbf      <= next_tbf;
      rbf      <= next_rbf;
      rov      <= next_rov;
      busy     <= next_busy;
      phase    <= next_phase;
      div      <= next_div;
      edges    <= next_edges;
      samples  <= next_samples;
      istat    <= next_istat;
      ien      <= next_ien;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      irq_o    <= next_irq;
      sck_o    <= next_sck;
      sck_oe_o <= next_sck_oe;
      sdo_o    <= next_sdo;
      sdo_oe_o <= next_sdo_oe;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tbf_on_write: assert property (wr_buf |=> tbf)
    else $error("transmit full flag not set by buffer write");
  a_tbf_on_load: assert property (load && !wr_buf |=> !tbf)
    else $error("transmit full flag not cleared by load");
  a_tbf_read_view: assert property (
    hit && !wb_we_i && !wb_ack_o && wb_adr_i == sbsf_pkg::ADR_STAT
    |=> wb_ack_o && wb_dat_o[sbsf_pkg::STAT_TBF] == $past(tbf))
    else $error("status read shows wrong transmit flag");
  a_rbf_on_done: assert property (
    done && !rbf |=> rbf && rxb == $past(word))
    else $error("received word not handed to buffer");
  a_sck_drive: assert property (
    ##1 sck_oe_o == $past(en && ctrl.msten && !ctrl.dis_sck))
    else $error("shift clock drive does not follow mode");
  a_ovf_discard: assert property (
    done && rbf && !rd_buf |=> rov && rxb == $past(rxb))
    else $error("overflow word not discarded");
  a_ovf_sticky: assert property (
    rov && !rov_clr |=> rov)
    else $error("overflow flag dropped without clear");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_irq_level: assert property (irq_o == |(istat & ien))
    else $error("interrupt level does not match status");

  c_master_word: cover property (ctrl.msten && done);
  c_slave_word:  cover property (!ctrl.msten && done);
  c_overflow:    cover property (done && rbf && !rd_buf);
  c_load_write:  cover property (load && wr_buf);
endmodule
`default_nettype wire

// ==== test/sbsf_peer.sv ====
// Serial peer that answers the port as slave or clocks it as master.
`default_nettype none
module sbsf_peer (
  input  wire logic dut_sck_i,  // Shift clock from the port
  input  wire logic dut_sdo_i,  // Serial data from the port
  output var  logic link_sck_o, // Shift clock into the port
  output logic      link_sdo_o, // Serial data into the port
  output var  logic link_ss_n_o // Slave select, low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  wire  logic sck_seen;
  // Both clocks rest low, so either role shows its edges here.
  assign sck_seen = dut_sck_i | link_sck_o;
  assign link_sdo_o = tx_q[7];
  initial begin
    link_sck_o = 1'b0;
    link_ss_n_o = 1'b1;
  end
  always @(posedge sck_seen) begin
    rx_q <= {rx_q[6:0], dut_sdo_i};
  end
  // Spent bits are refilled inverted, so the byte after a loaded one is its inverse and the loaded byte returns after 16 bits.
  always @(negedge sck_seen) begin
    tx_q <= {tx_q[6:0], ~tx_q[7]};
  end
  task automatic load(input logic [7:0] b);
    tx_q = b;
  endtask
  // One byte at 125 ns a bit; the clock rests low outside the frame.
  task automatic clock_byte();
    link_ss_n_o = 1'b0;
    repeat (8) begin
      #62.5 link_sck_o = 1'b1;
      #62.5 link_sck_o = 1'b0;
    end
    link_ss_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test/sbsf_core_tb_top.sv ====
// Self-checking bench for the serial buffer flag block.
`default_nettype none
module sbsf_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        wr_en = 1'b0;
  logic [4:0]  adr   = 5'h00;
  logic [31:0] wdat  = 32'h00000000;
  wire  logic [31:0] rdat;
  wire  logic  ack, irq, sck, sck_oe, sdo, sdo_oe, lsck, lsdi, ss_n;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #4 clk_i = ~clk_i;
  sbsf_core sbsf_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(wr_en), .wb_sel_i(4'h3), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .sck_i(lsck), .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(lsdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ss_n_i(ss_n));
  sbsf_peer sbsf_peer_inst (.dut_sck_i(sck), .dut_sdo_i(sdo),
    .link_sck_o(lsck), .link_sdo_o(lsdi), .link_ss_n_o(ss_n));
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    cyc   <= 1'b1;
    wr_en <= w;
    adr   <= a;
    wdat  <= {16'h0000, d};
    @(posedge clk_i);
    // Only the watchdog ends a wait for the acknowledge.
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string s, input logic [4:0] a,
                    input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(s, e, q);
  endtask
  // Polls the status register until a bit of the mask is seen set, or counts a mismatch after 200 reads.
  task automatic wait_stat(input logic [15:0] m);
    logic [15:0] q;
    int n;
    q = 16'h0000;
    n = 0;
    while ((q & m) == 16'h0000 && n < 200) begin
      wb(1'b0, sbsf_pkg::ADR_STAT, 16'h0000, q);
      n++;
    end
    if ((q & m) == 16'h0000) n_mismatch++;
  endtask
  task automatic t_reset();
    rd("stat", sbsf_pkg::ADR_STAT, 16'h0000);
    rd("ctrl", sbsf_pkg::ADR_CTRL, 16'h0000);
    rd("unmapped", 5'h1C, 16'h0000);
    chk("sck_oe", 16'h0000, {15'h0000, sck_oe});
    chk("sdo_oe", 16'h0000, {15'h0000, sdo_oe});
    chk("irq rst", 16'h0000, {15'h0000, irq});
  endtask
  task automatic t_master();
    sbsf_peer_inst.load(8'hA5);
    wr(sbsf_pkg::ADR_BUF, 16'h003C);
    rd("stat tbf", sbsf_pkg::ADR_STAT, 16'h0002);
    wr(sbsf_pkg::ADR_CTRL, 16'h0120);
    wr(sbsf_pkg::ADR_STAT, 16'h8000);
    rd("stat run", sbsf_pkg::ADR_STAT, 16'h8000);
    chk("sck_oe", 16'h0001, {15'h0000, sck_oe});
    chk("sdo_oe", 16'h0001, {15'h0000, sdo_oe});
    wait_stat(16'h0001);
    rd("stat done", sbsf_pkg::ADR_STAT, 16'h8001);
    chk("peer rx", 16'h003C, {8'h00, sbsf_peer_inst.rx_q});
    rd("rx buf", sbsf_pkg::ADR_BUF, 16'h00A5);
    rd("stat read", sbsf_pkg::ADR_STAT, 16'h8000);
  endtask
  task automatic t_overflow();
    sbsf_peer_inst.load(8'h5A);
    wr(sbsf_pkg::ADR_BUF, 16'h0011);
    wr(sbsf_pkg::ADR_BUF, 16'h0022);
    rd("stat queued", sbsf_pkg::ADR_STAT, 16'h8002);
    wait_stat(16'h0040);
    rd("stat ov", sbsf_pkg::ADR_STAT, 16'h8041);
    chk("peer rx2", 16'h0022, {8'h00, sbsf_peer_inst.rx_q});
    rd("rx kept", sbsf_pkg::ADR_BUF, 16'h005A);
    wr(sbsf_pkg::ADR_STAT, 16'h8040);
    rd("ov sticky", sbsf_pkg::ADR_STAT, 16'h8040);
    wr(sbsf_pkg::ADR_STAT, 16'h8000);
    rd("ov clear", sbsf_pkg::ADR_STAT, 16'h8000);
  endtask
  task automatic t_irq();
    rd("istat", sbsf_pkg::ADR_ISTA, 16'h0007);
    chk("irq off", 16'h0000, {15'h0000, irq});
    wr(sbsf_pkg::ADR_IEN, 16'h0004);
    rd("ien", sbsf_pkg::ADR_IEN, 16'h0004);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(sbsf_pkg::ADR_ICLR, 16'h0004);
    rd("iclr", sbsf_pkg::ADR_ICLR, 16'h0000);
    chk("irq clr", 16'h0000, {15'h0000, irq});
    rd("istat left", sbsf_pkg::ADR_ISTA, 16'h0003);
    wr(sbsf_pkg::ADR_ICLR, 16'h0003);
  endtask
  task automatic t_slave();
    wr(sbsf_pkg::ADR_CTRL, 16'h0100);
    rd("ctrl", sbsf_pkg::ADR_CTRL, 16'h0100);
    chk("sck_oe slv", 16'h0000, {15'h0000, sck_oe});
    chk("sdo_oe slv", 16'h0001, {15'h0000, sdo_oe});
    sbsf_peer_inst.load(8'hC3);
    wr(sbsf_pkg::ADR_BUF, 16'h0096);
    rd("stat slv", sbsf_pkg::ADR_STAT, 16'h8000);
    sbsf_peer_inst.clock_byte();
    @(posedge clk_i);
    wait_stat(16'h0001);
    rd("stat slv2", sbsf_pkg::ADR_STAT, 16'h8001);
    rd("rx slv", sbsf_pkg::ADR_BUF, 16'h00C3);
    chk("peer slv", 16'h0096, {8'h00, sbsf_peer_inst.rx_q});
  endtask
  // Word mode as master: the peer answers a byte and then its inverse.
  task automatic t_word();
    wr(sbsf_pkg::ADR_CTRL, 16'h0520);
    sbsf_peer_inst.load(8'hB4);
    wr(sbsf_pkg::ADR_BUF, 16'h1234);
    wait_stat(16'h0001);
    rd("stat word", sbsf_pkg::ADR_STAT, 16'h8001);
    rd("rx word", sbsf_pkg::ADR_BUF, 16'hB44B);
    chk("peer word", 16'h0034, {8'h00, sbsf_peer_inst.rx_q});
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_master();
    t_overflow();
    t_irq();
    t_slave();
    t_word();
    close_out();
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
